// ==== rtl/swm_regs.svh ====
// Purpose: Timing constants for the single-wire bus master.
// Assumes: SYS_CLK at 100 MHz.
// Notes: Times are in ns; cycle counts derive from them.
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH
`define SWM_CLK_NS 10
`define SWM_RST_LOW_STD_NS 500000
`define SWM_RST_LOW_OD_NS 60000
`define SWM_PDH_MAX_STD_NS 60000
`define SWM_PDH_MAX_OD_NS 6000
`define SWM_PDL_MIN_STD_NS 60000
`define SWM_PDL_MIN_OD_NS 8000
`define SWM_PDH_MIN_STD_NS 15000
`define SWM_PDH_MIN_OD_NS 2000
`define SWM_W0L_STD_NS 65000
`define SWM_W0L_OD_NS 7000
`define SWM_W1L_STD_NS 6000
`define SWM_W1L_OD_NS 1000
`define SWM_RDSMP_STD_NS 13000
`define SWM_RDSMP_OD_NS 1500
`define SWM_SLOT_STD_NS 70000
`define SWM_SLOT_OD_NS 10000
`define SWM_REC_OD_RST_NS 5000
`define SWM_PROG_NS 12500000
`define SWM_CYC(ns) (((ns) + `SWM_CLK_NS - 1) / `SWM_CLK_NS)
`define SWM_CMD_OD_SKIP 8'h3C
`define SWM_CMD_OD_MATCH 8'h69
`endif

// ==== rtl/swm_pkg.sv ====
// Purpose: Types for the single-wire bus master.
// Assumes: Nothing.
// Notes: Constants live in swm_regs.svh.
package swm_pkg;
  typedef enum logic [2:0] {
    SWM_IDLE = 3'b000,
    SWM_RST_LOW = 3'b001,
    SWM_PRES = 3'b010,
    SWM_SLOT = 3'b011,
    SWM_PROG = 3'b100
  } swm_state_t;
  typedef enum logic [1:0] {
    SWM_OP_RESET = 2'b00,
    SWM_OP_BYTE = 2'b01,
    SWM_OP_PROG = 2'b10
  } swm_op_t;
endpackage

// ==== rtl/swm_if.sv ====
// Purpose: Slot timer request and done between master and timer.
// Assumes: One clock.
// Notes: Load is a pulse; expired stands until the next load.
`timescale 1ns/1ns
interface swm_tmr_if;
  logic load;
  logic [20:0] count;
  logic expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface

// ==== rtl/swm_timer.sv ====
// Purpose: Down counter for slot, reset and wait intervals.
// Assumes: Count of zero expires after one cycle.
// Notes: Shared by all phases so only one interval runs at a time.
`timescale 1ns/1ns
module swm_timer (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Timer port
  swm_tmr_if.tmr t
);
  logic [20:0] cnt_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cnt_q <= 21'h000000;
    end else if (t.load) begin
      cnt_q <= t.count;
    end else if (cnt_q != 21'h000000) begin
      cnt_q <= cnt_q - 21'h000001;
    end
  end
  // Expiry must not look at load: the controller raises load because of expiry.
  assign t.expired = (cnt_q == 21'h000000);
endmodule // swm_timer

// ==== rtl/swm_master.sv ====
// Purpose: Bus master for a single-conductor open-drain serial link.
// Assumes: BUS_IN is synchronous to SYS_CLK.
// Notes: Speed is tracked from command bytes the master itself sends.
`timescale 1ns/1ns
`include "swm_regs.svh"
module swm_master
  import swm_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Command port
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [1:0] CMD_OP,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_SELECT,
  // Answer port
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_PRESENT,
  output logic RSP_ERROR,
  output logic OVERDRIVE,
  // Bus pin
  input wire logic BUS_IN,
  output logic BUS_OUT,
  output logic BUS_OE
);
  localparam logic [20:0] C_RST_STD = 21'(`SWM_CYC(`SWM_RST_LOW_STD_NS));
  localparam logic [20:0] C_RST_OD = 21'(`SWM_CYC(`SWM_RST_LOW_OD_NS));
  localparam logic [20:0] C_PSMP_STD = 21'(`SWM_CYC(`SWM_PDH_MAX_STD_NS));
  localparam logic [20:0] C_PSMP_OD = 21'(`SWM_CYC(`SWM_PDH_MAX_OD_NS));
  localparam logic [20:0] C_PEND_STD = 21'(`SWM_CYC(`SWM_PDL_MIN_STD_NS * 4));
  localparam logic [20:0] C_PEND_OD = 21'(`SWM_CYC(`SWM_PDL_MIN_OD_NS * 3));
  localparam logic [20:0] C_W0_STD = 21'(`SWM_CYC(`SWM_W0L_STD_NS));
  localparam logic [20:0] C_W0_OD = 21'(`SWM_CYC(`SWM_W0L_OD_NS));
  localparam logic [20:0] C_W1_STD = 21'(`SWM_CYC(`SWM_W1L_STD_NS));
  localparam logic [20:0] C_W1_OD = 21'(`SWM_CYC(`SWM_W1L_OD_NS));
  localparam logic [20:0] C_RS_STD = 21'(`SWM_CYC(`SWM_RDSMP_STD_NS));
  localparam logic [20:0] C_RS_OD = 21'(`SWM_CYC(`SWM_RDSMP_OD_NS));
  localparam logic [20:0] C_RD_STD = C_RS_STD - C_W1_STD - 21'h000002;
  localparam logic [20:0] C_RD_OD = C_RS_OD - C_W1_OD - 21'h000002;
  localparam logic [20:0] C_SL_STD = 21'(`SWM_CYC(`SWM_SLOT_STD_NS));
  localparam logic [20:0] C_SL_OD = 21'(`SWM_CYC(`SWM_SLOT_OD_NS));
  localparam logic [20:0] C_PROG = 21'(`SWM_CYC(`SWM_PROG_NS));

  function automatic logic [20:0] pick(input logic od, input logic [20:0] s,
                                       input logic [20:0] o);
    pick = od ? o : s;
  endfunction

  swm_tmr_if tif ();
  swm_timer u_timer (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .t(tif));

  swm_state_t state_q;
  logic od_q;
  logic sel_q;
  logic sel_pend_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [1:0] ph_q;
  logic drive_q;
  logic pres_q;
  logic go;
  logic byte_done;
  logic od_pend_q;

  assign CMD_READY = (state_q == SWM_IDLE);
  assign go = CMD_VALID && CMD_READY;
  assign BUS_OUT = 1'b0;
  assign BUS_OE = drive_q;
  assign OVERDRIVE = od_q;
  assign byte_done = (state_q == SWM_SLOT) && tif.expired && (ph_q == 2'h1) && (bit_q == 3'h7);

  // The timer loads on entry to each phase; phases are two per slot.
  always_comb begin
    tif.load = 1'b0;
    tif.count = 21'h000000;
    if (go) begin
      tif.load = 1'b1;
      case (CMD_OP)
        SWM_OP_RESET: tif.count = pick(od_q && !CMD_DATA[0], C_RST_STD, C_RST_OD);
        SWM_OP_PROG: tif.count = C_PROG;
        default: tif.count = pick(od_q, C_W1_STD, C_W1_OD);
      endcase
      if (CMD_OP == SWM_OP_BYTE && !CMD_DATA[0]) begin
        tif.count = pick(od_q, C_W0_STD, C_W0_OD);
      end
    end else if (tif.expired) begin
      case (state_q)
        SWM_RST_LOW: begin
          tif.load = 1'b1;
          tif.count = pick(od_q, C_PSMP_STD, C_PSMP_OD);
        end
        SWM_PRES: begin
          if (ph_q == 2'd0) begin
            tif.load = 1'b1;
            tif.count = pick(od_q, C_PEND_STD, C_PEND_OD);
          end
        end
        SWM_SLOT: begin
          tif.load = 1'b1;
          if (ph_q == 2'd0) begin
            tif.count = pick(od_q, C_SL_STD, C_SL_OD) - (sh_q[0] ?
              pick(od_q, C_W1_STD, C_W1_OD) : pick(od_q, C_W0_STD, C_W0_OD));
          end else if (bit_q != 3'd7) begin
            tif.count = sh_q[1] ? pick(od_q, C_W1_STD, C_W1_OD) :
              pick(od_q, C_W0_STD, C_W0_OD);
          end else begin
            tif.load = 1'b0;
          end
        end
        default: tif.load = 1'b0;
      endcase
    end
  end

  // The read sample falls after the write-one release, so it is timed in the second phase.
  logic [20:0] age_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      age_q <= 21'h000000;
    end else if (tif.load) begin
      age_q <= 21'h000000;
    end else begin
      age_q <= age_q + 21'h000001;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_q <= SWM_IDLE;
      ph_q <= 2'd0;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      drive_q <= 1'b0;
      pres_q <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_PRESENT <= 1'b0;
      RSP_ERROR <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state_q)
        SWM_IDLE: begin
          if (go) begin
            RSP_ERROR <= 1'b0;
            ph_q <= 2'd0;
            bit_q <= 3'd0;
            sh_q <= CMD_DATA;
            case (CMD_OP)
              SWM_OP_RESET: begin
                state_q <= SWM_RST_LOW;
                drive_q <= 1'b1;
              end
              SWM_OP_PROG: state_q <= SWM_PROG;
              SWM_OP_BYTE: begin
                if (!sel_q && !CMD_SELECT) begin
                  RSP_ERROR <= 1'b1;
                  RSP_VALID <= 1'b1;
                end else begin
                  state_q <= SWM_SLOT;
                  drive_q <= 1'b1;
                end
              end
              default: begin
                RSP_ERROR <= 1'b1;
                RSP_VALID <= 1'b1;
              end
            endcase
          end
        end
        SWM_RST_LOW: if (tif.expired) begin
          drive_q <= 1'b0;
          state_q <= SWM_PRES;
        end
        SWM_PRES: if (tif.expired) begin
          if (ph_q == 2'd0) begin
            pres_q <= !BUS_IN;
            ph_q <= 2'd1;
          end else begin
            RSP_PRESENT <= pres_q;
            RSP_VALID <= 1'b1;
            state_q <= SWM_IDLE;
          end
        end
        SWM_SLOT: begin
          if (ph_q == 2'h1 && sh_q[0] && age_q == pick(od_q, C_RD_STD, C_RD_OD)) begin
            sh_q[0] <= BUS_IN;
          end
          if (tif.expired) begin
            if (ph_q == 2'd0) begin
              drive_q <= 1'b0;
              ph_q <= 2'd1;
            end else begin
              sh_q <= {sh_q[0], sh_q[7:1]};
              ph_q <= 2'd0;
              if (bit_q == 3'd7) begin
                RSP_DATA <= {sh_q[0], sh_q[7:1]};
                RSP_VALID <= 1'b1;
                state_q <= SWM_IDLE;
              end else begin
                bit_q <= bit_q + 3'd1;
                drive_q <= 1'b1;
              end
            end
          end
        end
        SWM_PROG: if (tif.expired) begin
          RSP_VALID <= 1'b1;
          state_q <= SWM_IDLE;
        end
        default: state_q <= SWM_IDLE;
      endcase
    end
  end

  // Overdrive is entered only after the whole overdrive selection byte went out at standard speed; a reset with CMD_DATA[0] set leaves it at once.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sel_q <= 1'b0;
      sel_pend_q <= 1'b0;
      od_pend_q <= 1'b0;
      od_q <= 1'b0;
    end else if (go && CMD_OP == SWM_OP_RESET) begin
      sel_q <= 1'b0;
      sel_pend_q <= 1'b0;
      od_pend_q <= 1'b0;
      if (od_q && CMD_DATA[0]) begin
        od_q <= 1'b0;
      end
    end else if (go && CMD_OP == SWM_OP_BYTE && CMD_SELECT) begin
      sel_pend_q <= 1'b1;
      od_pend_q <= !od_q && (CMD_DATA == `SWM_CMD_OD_SKIP || CMD_DATA == `SWM_CMD_OD_MATCH);
    end else if (byte_done && sel_pend_q) begin
      sel_q <= 1'b1;
      sel_pend_q <= 1'b0;
      od_pend_q <= 1'b0;
      if (od_pend_q) begin
        od_q <= 1'b1;
      end
    end
  end

  property p_no_mem_before_sel;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (go && CMD_OP == SWM_OP_BYTE && !CMD_SELECT && !sel_q) |=> (RSP_ERROR && RSP_VALID);
  endproperty
  a_no_mem_before_sel: assert property (p_no_mem_before_sel) else $error("memory byte accepted");

  property p_reset_len;
    @(posedge SYS_CLK) disable iff (!RST_N)
      $rose(drive_q) && state_q == SWM_RST_LOW && !od_q |-> drive_q [*8];
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset pulse too short");

  property p_od_switch;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (byte_done && od_pend_q) |=> od_q;
  endproperty
  a_od_switch: assert property (p_od_switch) else $error("overdrive not entered");

  property p_od_steady;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (state_q == SWM_SLOT) |-> $stable(od_q);
  endproperty
  a_od_steady: assert property (p_od_steady) else $error("speed changed inside a byte");

  property p_release_idle;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (state_q == SWM_IDLE) |-> !drive_q;
  endproperty
  a_release_idle: assert property (p_release_idle) else $error("bus held while idle");

  property p_prog_busy;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (go && CMD_OP == SWM_OP_PROG) |=> !CMD_READY [*8];
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("traffic during programming");
endmodule // swm_master

// ==== tb/swm_dev_model.sv ====
// Purpose: Behavioural slave device that stands on the single-wire bus.
// Assumes: The line is pulled up whenever nobody pulls it low.
// Notes: Serves presence, write slots and read slots; there is no memory array.
`timescale 1ns/1ns
module swm_dev_model #(
  parameter logic [7:0] RD_BYTE = 8'h1E
) (
  input wire logic line,
  output logic pull
);
  logic od = 1'b0;
  logic rd_mode = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] got = 8'h00;
  logic b;
  int nbit = 0;
  int nbyte = 0;
  time t0 = 0;
  time low_t = 0;
  initial pull = 1'b0;
  // The delays to the sample and to the presence pulse end in 5 ns so that the model never moves on a rising clock edge.
  always begin
    @(negedge line);
    t0 = $time;
    if (rd_mode) pull = ~RD_BYTE[nbit];
    #(od ? 3005 : 30005);
    b = line;
    pull = 1'b0;
    wait (line === 1'b1);
    low_t = $time - t0;
    if (low_t >= (od ? 48000 : 480000)) begin
      if (low_t >= 480000) od = 1'b0;
      #(od ? 3005 : 30005) pull = 1'b1;
      #(od ? 12000 : 100000) pull = 1'b0;
      nbit = 0;
      nbyte = 0;
      rd_mode = 1'b0;
    end else begin
      sh = {b, sh[7:1]};
      nbit++;
      if (nbit == 8) begin
        got = sh;
        nbit = 0;
        nbyte++;
        if (nbyte == 1 && !od && (sh == 8'h3C || sh == 8'h69)) od = 1'b1;
        if (nbyte == 2) rd_mode = 1'b1;
      end
    end
    #(od ? 0 : 2000);
  end
endmodule // swm_dev_model

// ==== tb/single_wire_slave_protocol_timing_tb_top.sv ====
// Purpose: Self-checking bench for the single-wire bus master.
// Assumes: One device model on the line, pulled up when released.
// Notes: The programming wait is left out; it alone would exceed the run budget.
`timescale 1ns/1ns
module single_wire_slave_protocol_timing_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_select = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_present;
  logic rsp_error;
  logic overdrive;
  logic bus_out;
  logic bus_oe;
  logic pull;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  time tb4;
  wire line = (bus_oe ? bus_out : 1'b1) & ~pull;

  initial forever #5 sys_clk = ~sys_clk;

  swm_master i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .CMD_SELECT(cmd_select),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_PRESENT(rsp_present),
    .RSP_ERROR(rsp_error), .OVERDRIVE(overdrive), .BUS_IN(line), .BUS_OUT(bus_out),
    .BUS_OE(bus_oe));
  swm_dev_model i_dev (.line(line), .pull(pull));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic op(input logic [1:0] o, input logic [7:0] d, input logic s);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_data = d;
    cmd_select = s;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cyc = 0;
    while (rsp_valid !== 1'b1 && cyc < 100000) begin
      @(negedge sys_clk);
      cyc++;
    end
    chk("answer in time", cyc < 100000, 1);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic t_std_reset;
    op(2'h0, 8'h01, 1'b0);
    chk("presence std", rsp_present, 1);
    chk("reset low std", i_dev.low_t >= 480000 && i_dev.low_t <= 640000, 1);
    $display("test std_reset done");
  endtask

  task automatic t_refuse;
    tb4 = i_dev.t0;
    op(2'h1, 8'hF0, 1'b0);
    chk("refused", rsp_error, 1);
    chk("refusal latency", cyc <= 2, 1);
    chk("no slot on refusal", i_dev.t0 == tb4, 1);
    $display("test refuse done");
  endtask

  task automatic t_od_select;
    op(2'h1, 8'h3C, 1'b1);
    chk("select accepted", rsp_error, 0);
    chk("byte lsb first", i_dev.got, 8'h3C);
    chk("std byte length", cyc >= 8 * 6500, 1);
    chk("write zero low", i_dev.low_t >= 60000 && i_dev.low_t <= 120000, 1);
    chk("overdrive flag", overdrive, 1);
    chk("device overdrive", i_dev.od, 1);
    $display("test od_select done");
  endtask

  task automatic t_od_traffic;
    op(2'h0, 8'h00, 1'b0);
    chk("presence od", rsp_present, 1);
    chk("reset low od", i_dev.low_t >= 48000 && i_dev.low_t <= 80000, 1);
    chk("still overdrive", overdrive, 1);
    op(2'h1, 8'hCC, 1'b1);
    chk("od select", i_dev.got, 8'hCC);
    op(2'h1, 8'h0F, 1'b0);
    chk("memory accepted", rsp_error, 0);
    chk("memory byte", i_dev.got, 8'h0F);
    chk("od write zero low", i_dev.low_t >= 6000 && i_dev.low_t <= 15500, 1);
    op(2'h1, 8'hFF, 1'b0);
    chk("read byte", rsp_data, 8'h1E);
    chk("od byte length", cyc >= 8 * 800, 1);
    $display("test od_traffic done");
  endtask

  // The run needs about 1.7 ms; this limit leaves room without hiding a hang.
  initial begin
    #3000000;
    n_fail++;
    tally_and_finish;
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    t_std_reset;
    t_refuse;
    t_od_select;
    t_od_traffic;
    tally_and_finish;
  end
endmodule // single_wire_slave_protocol_timing_tb_top
